// >>> tb/xma_ext_access_bench.sv
`timescale 1ns/10ps
// ----
// bench
// ----
module xma_ext_access_bench;
    localparam [31:0] WK0 = 32'h00000100;
    localparam [31:0] WK1 = 32'h00000008;
    reg core_clk = 0, srst = 1, linkClk = 0, busWrite = 0, eeWriteOk = 0, shadowWriteOk = 0;
    reg slow = 0, abortNext = 0;
    reg [5:0] busAddr = 6'h00;
    reg [7:0] busWdata = 8'h00;
    wire [7:0] busRdata, memAddr;
    wire memReq, memWrite, memDone, memAbort, xeeWarn, xeeErr;
    wire [31:0] memWdata, memRdata;
    wire [1:0] memMargin;
    integer num_errors = 0, checked = 0, seed = 32'h6dd4, i, n, k;
    reg [31:0] data, got, m;
    reg [7:0] b, adr;
    reg [3:0] c;
    // reference contents of the extended space, as the host expects to read them back
    reg [31:0] refMem [0:127];
    always #5 core_clk = ~core_clk;
    xma_ext_access #(.EE_WRITE_CYCLES(500)) u_xma_ext_access (.core_clk(core_clk), .srst(srst),
        .linkClk(linkClk), .busAddr(busAddr), .busWdata(busWdata), .busWrite(busWrite),
        .busRdata(busRdata), .eeWriteOk(eeWriteOk), .shadowWriteOk(shadowWriteOk), .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memMargin(memMargin),
        .memRdata(memRdata), .memDone(memDone), .memAbort(memAbort), .xeeWarn(xeeWarn), .xeeErr(xeeErr));
    xma_mem_model #(.W0(WK0), .W1(WK1)) u_xma_mem_model (.core_clk(core_clk), .memReq(memReq),
        .memWrite(memWrite), .memAddr(memAddr), .memWdata(memWdata), .memMargin(memMargin), .slow(slow),
        .abortNext(abortNext), .memRdata(memRdata), .memDone(memDone), .memAbort(memAbort));
    task check(input [31:0] seen, input [31:0] want);
        begin
            checked = checked + 1;
            if (seen !== want) begin
                num_errors = num_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task end_sim;
        begin
            if (num_errors == 0 && checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // one link period of 170 ns; byte under the address is taken at its close
    task acc(input [5:0] a, input [7:0] d, input w);
        begin
            @(posedge core_clk);
            busAddr <= a;
            busWdata <= d;
            busWrite <= w;
            repeat (8) @(posedge core_clk);
            linkClk <= 1'b1;
            repeat (8) @(posedge core_clk);
            linkClk <= 1'b0;
            b = busRdata;
        end
    endtask
    task poll(input [5:0] a);
        begin
            n = 0;
            b = 8'h00;
            while (b[0] !== 1'b1 && n < 40) begin
                acc(a, 8'h00, 1'b0);
                n = n + 1;
            end
            if (b[0] !== 1'b1) begin
                num_errors = num_errors + 1;
                end_sim;
            end
        end
    endtask
    task wr32(input [7:0] ad, input [31:0] d);
        begin
            acc(6'h03, ad, 1'b1);
            for (i = 0; i < 4; i = i + 1)
                acc(6'h04 + i, d[31 - 8 * i -: 8], 1'b1);
            acc(6'h08, 8'h80, 1'b1);
            poll(6'h09);
        end
    endtask
    task rd32(input [7:0] ad, output [31:0] d);
        begin
            acc(6'h0B, ad, 1'b1);
            acc(6'h0C, 8'h80, 1'b1);
            poll(6'h0D);
            for (i = 0; i < 4; i = i + 1) begin
                acc(6'h0E + i, 8'h00, 1'b0);
                d = {d[23:0], b};
            end
        end
    endtask
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors = num_errors + 1;
        end_sim;
    end
    initial begin
        for (i = 0; i < 128; i = i + 1)
            refMem[i] = 32'h0000_0000;
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        eeWriteOk <= 1'b1;
        shadowWriteOk <= 1'b1;
        @(posedge core_clk);
        check({memMargin, xeeWarn, xeeErr, memReq}, 32'h0);
        for (k = 0; k < 4; k = k + 1) begin
            adr = ($random(seed) & 8'h1F) + (k[0] ? 8'h40 : 8'h00);
            data = $random(seed);
            wr32(adr, data);
            refMem[adr] = {data[31:26], 2'b00, data[23:0]};
            rd32(adr, got);
            check(got, refMem[adr]);
        end
        eeWriteOk <= 1'b0;
        wr32(8'h10, data);
        check(xeeWarn, 1'b1);
        rd32(8'h10, got);
        check(got, refMem[8'h10]);
        acc(6'h1E, 8'h02, 1'b1);
        check(xeeWarn, 1'b0);
        shadowWriteOk <= 1'b0;
        wr32(8'h5A, data);
        check(xeeWarn, 1'b1);
        acc(6'h1E, 8'h02, 1'b1);
        shadowWriteOk <= 1'b1;
        rd32(8'h60, got);
        check(got, 32'h0000_0000);
        eeWriteOk <= 1'b1;
        abortNext <= 1'b1;
        wr32(8'h05, data);
        abortNext <= 1'b0;
        check({xeeWarn, xeeErr}, 2'b11);
        acc(6'h1E, 8'h03, 1'b1);
        check({xeeWarn, xeeErr}, 2'b00);
        // weak cell WK0 is cleared and WK1 set in the word, so each threshold flips a bit and both show
        data = ($random(seed) & ~WK0) | WK1;
        wr32(8'h12, data);
        check({xeeWarn, xeeErr}, 2'b00);
        for (k = 0; k < 3; k = k + 1) begin
            c = (k == 2) ? 4'h0 : k + 1;
            slow <= (k == 2);
            acc(6'h1E, {c, 4'h0}, 1'b1);
            acc(6'h1F, 8'hA5, 1'b1);
            acc(6'h1E, 8'h00, 1'b0);
            check(b, {c, 4'h0});
            check(memMargin, c[1:0]);
            rd32(8'h12, got);
            m = (data | (c == 4'h1 ? WK0 : 32'h0)) & ~(c == 4'h2 ? WK1 : 32'h0);
            check(got, {m[31:26], 2'b00, m[23:0]});
        end
        check(n <= 14, 1'b1);
        acc(6'h1E, 8'h10, 1'b1);
        acc(6'h1F, 8'hA5, 1'b1);
        srst <= 1'b1;
        repeat (4) @(posedge core_clk);
        srst <= 1'b0;
        acc(6'h1E, 8'h00, 1'b0);
        check({b, memMargin}, 10'h000);
        end_sim;
    end
endmodule

// >>> tb/xma_ext_access_checker.sv
`timescale 1ns/10ps
// ----
// port checker
// ----
module xma_ext_access_checker #(
    parameter EE_WRITE_CYCLES = 500
) (
    input wire core_clk,
    input wire srst,
    input wire eeWriteOk,
    input wire memReq,
    input wire memWrite,
    input wire [7:0] memAddr,
    input wire [1:0] memMargin,
    input wire memDone,
    input wire memAbort,
    input wire xeeWarn,
    input wire xeeErr
);
    // length of the current write, to bound it without a long repetition
    integer wrCnt;
    always @(posedge core_clk) begin
        if (srst || !memWrite)
            wrCnt <= 0;
        else
            wrCnt <= wrCnt + 1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    a_req_pulse: assert property (memReq |=> !memReq)
        else $error("start pulse longer than one cycle");
    a_locked_write: assert property (memReq && memWrite |-> eeWriteOk && memAddr <= 8'h3F)
        else $error("locked or out of range write reached memory");
    a_write_end: assert property (memWrite && (memDone || memAbort) |-> ##[1:2] !memWrite)
        else $error("write not ended by completion");
    a_write_bound: assert property (wrCnt <= EE_WRITE_CYCLES + 2)
        else $error("write outlived its time limit");
    a_abort_err: assert property (memWrite && memAbort |-> ##[1:2] xeeErr)
        else $error("abort did not raise error flag");
    a_err_cause: assert property ($rose(xeeErr) |-> $past(memWrite) || $past(memWrite, 2))
        else $error("error flag without a write");
    a_err_warn: assert property ($rose(xeeErr) |-> ##[0:1] xeeWarn)
        else $error("abort did not raise warning flag");
    a_margin_code: assert property (memMargin != 2'b11)
        else $error("illegal threshold code");
endmodule

bind xma_ext_access xma_ext_access_checker #(.EE_WRITE_CYCLES(EE_WRITE_CYCLES)) u_chk (
    .core_clk(core_clk), .srst(srst), .eeWriteOk(eeWriteOk), .memReq(memReq),
    .memWrite(memWrite), .memAddr(memAddr), .memMargin(memMargin), .memDone(memDone),
    .memAbort(memAbort), .xeeWarn(xeeWarn), .xeeErr(xeeErr));

// >>> tb/xma_mem_model.sv
`timescale 1ns/10ps
// ----
// cell array with weak bits
// ----
module xma_mem_model #(
    parameter [31:0] W0 = 32'h00000100,
    parameter [31:0] W1 = 32'h00000008
) (
    input wire core_clk,
    input wire memReq,
    input wire memWrite,
    input wire [7:0] memAddr,
    input wire [31:0] memWdata,
    input wire [1:0] memMargin,
    input wire slow,
    input wire abortNext,
    output reg [31:0] memRdata,
    output reg memDone,
    output reg memAbort
);
    reg [31:0] store [0:63];
    reg [31:0] w;
    reg [7:0] a;
    reg wr;
    integer k;
    initial begin
        memDone = 0;
        memAbort = 0;
        memRdata = 32'h0;
        for (k = 0; k < 64; k = k + 1)
            store[k] = 32'h0;
        forever begin
            @(posedge core_clk);
            if (memReq) begin
                a = memAddr;
                wr = memWrite;
                w = memWdata;
                repeat (slow ? 150 : (wr ? 40 : 5)) @(posedge core_clk);
                if (wr && abortNext)
                    memAbort <= 1'b1;
                else if (wr) begin
                    store[a[5:0]] = w;
                    memDone <= 1'b1;
                end else begin
                    // weak cells flip with the threshold; spare bits left set on purpose
                    w = store[a[5:0]] | (memMargin == 2'b01 ? W0 : 32'h0);
                    w = w & ~(memMargin == 2'b10 ? W1 : 32'h0);
                    memRdata <= {w[31:26], 2'b11, w[23:0]};
                    memDone <= 1'b1;
                end
                @(posedge core_clk);
                memDone <= 1'b0;
                memAbort <= 1'b0;
                memRdata <= ~memRdata;
            end
        end
    end
endmodule

// >>> verilog/xma_consts.vh
`ifndef XMA_CONSTS_VH
`define XMA_CONSTS_VH
// serial register byte addresses
`define XMA_ADR_EWA_LO 6'h03
`define XMA_ADR_EWD0 6'h04
`define XMA_ADR_EWD1 6'h05
`define XMA_ADR_EWD2 6'h06
`define XMA_ADR_EWD3 6'h07
`define XMA_ADR_WCTL_HI 6'h08
`define XMA_ADR_WCTL_LO 6'h09
`define XMA_ADR_ERA_LO 6'h0B
`define XMA_ADR_RCTL_HI 6'h0C
`define XMA_ADR_RCTL_LO 6'h0D
`define XMA_ADR_ERD0 6'h0E
`define XMA_ADR_ERD1 6'h0F
`define XMA_ADR_ERD2 6'h10
`define XMA_ADR_ERD3 6'h11
`define XMA_ADR_CTRL_HI 6'h1E
`define XMA_ADR_CTRL_LO 6'h1F
// field positions and codes
`define XMA_START_BIT 7
`define XMA_BUSY_BIT 0
`define XMA_DONE_BIT 0
`define XMA_CLW_BIT 1
`define XMA_CLE_BIT 0
`define XMA_INIT_KEY 8'hA5
`define XMA_SPC_NORMAL 4'h0
`define XMA_SPC_LOW 4'h1
`define XMA_SPC_HIGH 4'h2
// extended address map
`define XMA_SHADOW_BASE 8'h40
`define XMA_SHADOW_END 8'h5F
`define XMA_EE_END 8'h3F
// timing
`define XMA_CLK_MHZ 100
`define XMA_EE_READ_NS 2000
`define XMA_EE_WRITE_US 24000
`define XMA_RESET_BYTE 8'h00
`endif

// >>> verilog/xma_ext_access.v
`timescale 1ns/10ps
// Summary of operation
// R01: host loads write data MSB first
// R02: host starts write, polls done bit
// R03: second byte at 0x09 carries done flag
// R04: violation ends access, sets done, warns
// R05: aborted eeprom write sets error flag
// R06: host margin-checks after programming
// R07: special 0001 selects lowered read threshold
// R08: special 0010 selects raised read threshold
// R09: margin setting persists until cleared
// R10: special value confirmed by 0xA5 write
// R11: host follows margin procedure order
// R12: host checks error flags, rewrites failures
// R13: host loads read address first
// R14: start bit reads location into data
// R15: eeprom read completes within 2 us
// R16: shadow read done one cycle after sync
// R17: read done flag in byte 0x0D bit0
// R18: host avoids data read while busy
// R19: read word has crc, zeros, payload
// R20: host fetches high half then low
// R21: commands may pipeline with responses
// R22: shadow sits 0x40 above eeprom address
// R23: host loads write address first
// R24: eeprom write up to 24 ms
// R25: host unlocks with key sequence
`include "xma_consts.vh"

module xma_ext_access #(
    parameter EE_WRITE_CYCLES = `XMA_EE_WRITE_US * `XMA_CLK_MHZ
) (
    input wire core_clk,
    input wire srst,
    input wire linkClk,
    input wire [5:0] busAddr,
    input wire [7:0] busWdata,
    input wire busWrite,
    output reg [7:0] busRdata,
    input wire eeWriteOk,
    input wire shadowWriteOk,
    output reg memReq,
    output reg memWrite,
    output reg [7:0] memAddr,
    output reg [31:0] memWdata,
    output reg [1:0] memMargin,
    input wire [31:0] memRdata,
    input wire memDone,
    input wire memAbort,
    output reg xeeWarn,
    output reg xeeErr
);
    // ---------------------------------------------------------------
    // constants and helpers
    // ---------------------------------------------------------------
    localparam [31:0] RD_CYCLES = (`XMA_EE_READ_NS * `XMA_CLK_MHZ) / 1000;
    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_WAIT = 2'd1;

    function isShadow;
        input [7:0] a;
        begin
            isShadow = (a >= `XMA_SHADOW_BASE) && (a <= `XMA_SHADOW_END);
        end
    endfunction

    // ---------------------------------------------------------------
    // link synchronisers
    // ---------------------------------------------------------------
    // the link signals are held stable around the rising link edge, so
    // they are sampled once the synchronised edge is seen
    reg linkS1, linkS2, linkS3;
    reg [5:0] addrS1, addrS2;
    reg [7:0] dataS1, dataS2;
    reg wrS1, wrS2;
    wire linkRise = linkS2 & ~linkS3;
    wire wrStb = linkRise & wrS2; // R21

    always @(posedge core_clk) begin
        if (srst) begin
            linkS1 <= 1'b0;
            linkS2 <= 1'b0;
            linkS3 <= 1'b0;
            addrS1 <= 6'h00;
            addrS2 <= 6'h00;
            dataS1 <= 8'h00;
            dataS2 <= 8'h00;
            wrS1 <= 1'b0;
            wrS2 <= 1'b0;
        end else begin
            linkS1 <= linkClk;
            linkS2 <= linkS1;
            linkS3 <= linkS2;
            addrS1 <= busAddr;
            addrS2 <= addrS1;
            dataS1 <= busWdata;
            dataS2 <= dataS1;
            wrS1 <= busWrite;
            wrS2 <= wrS1;
        end
    end

    // ---------------------------------------------------------------
    // serial registers and engine
    // ---------------------------------------------------------------
    reg [7:0] wrAddr;
    reg [31:0] wrData;
    reg [7:0] rdAddr;
    reg [31:0] rdData;
    reg [3:0] special;
    reg [3:0] specialPend;
    reg writeBusy, writeDone, readBusy, readDone;
    reg [1:0] state;
    reg [21:0] waitCnt;
    reg [31:0] shadowMem [0:31];

    wire wrStart = wrStb && (addrS2 == `XMA_ADR_WCTL_HI) && dataS2[`XMA_START_BIT];
    wire rdStart = wrStb && (addrS2 == `XMA_ADR_RCTL_HI) && dataS2[`XMA_START_BIT];
    wire ctrlLoWr = wrStb && (addrS2 == `XMA_ADR_CTRL_LO);
    wire ctrlHiWr = wrStb && (addrS2 == `XMA_ADR_CTRL_HI);
    wire wrTimeout = (waitCnt >= EE_WRITE_CYCLES[21:0]);
    wire rdTimeout = (waitCnt >= RD_CYCLES[21:0]);
    wire wrLegal = isShadow(wrAddr) ? shadowWriteOk : ((wrAddr <= `XMA_EE_END) && eeWriteOk);
    wire wrAbortEvt = (state == ST_WAIT) && writeBusy && (memAbort || (!memDone && wrTimeout));
    wire wrFailEvt = (state == ST_IDLE) && wrStart && !wrLegal;
    wire clwEvt = ctrlHiWr && dataS2[`XMA_CLW_BIT];
    wire cleEvt = ctrlHiWr && dataS2[`XMA_CLE_BIT];

    always @(posedge core_clk) begin
        if (srst) begin
            wrAddr <= 8'h00;
            wrData <= 32'h0000_0000;
            rdAddr <= 8'h00;
            specialPend <= `XMA_SPC_NORMAL;
        end else if (wrStb) begin
            case (addrS2)
                `XMA_ADR_EWA_LO: wrAddr <= dataS2; // R23
                `XMA_ADR_EWD0: wrData[31:24] <= dataS2; // R01
                `XMA_ADR_EWD1: wrData[23:16] <= dataS2;
                `XMA_ADR_EWD2: wrData[15:8] <= dataS2;
                `XMA_ADR_EWD3: wrData[7:0] <= dataS2;
                `XMA_ADR_ERA_LO: rdAddr <= dataS2; // R13
                `XMA_ADR_CTRL_HI: specialPend <= dataS2[7:4];
                default: wrAddr <= wrAddr;
            endcase
        end
    end

    // margin threshold only moves on the 0xA5 confirm; other special codes are
    // not persistent here, so they read back as normal
    always @(posedge core_clk) begin
        if (srst) begin
            special <= `XMA_SPC_NORMAL;
            memMargin <= 2'b00;
        end else if (ctrlLoWr && dataS2 == `XMA_INIT_KEY) begin // R10
            case (specialPend)
                `XMA_SPC_LOW: begin // R07
                    special <= specialPend;
                    memMargin <= 2'b01;
                end
                `XMA_SPC_HIGH: begin // R08
                    special <= specialPend;
                    memMargin <= 2'b10;
                end
                default: begin // R09
                    special <= `XMA_SPC_NORMAL;
                    memMargin <= 2'b00;
                end
            endcase
        end
    end

    // warning and error flags: a hardware set wins over a clear
    always @(posedge core_clk) begin
        if (srst) begin
            xeeWarn <= 1'b0;
            xeeErr <= 1'b0;
        end else begin
            if (wrFailEvt || wrAbortEvt) begin
                xeeWarn <= 1'b1; // R04
            end else if (clwEvt) begin
                xeeWarn <= 1'b0;
            end
            if (wrAbortEvt) begin
                xeeErr <= 1'b1; // R05
            end else if (cleEvt) begin
                xeeErr <= 1'b0;
            end
        end
    end

    always @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            waitCnt <= 22'd0;
            writeBusy <= 1'b0;
            writeDone <= 1'b0;
            readBusy <= 1'b0;
            readDone <= 1'b0;
            rdData <= 32'h0000_0000;
            memReq <= 1'b0;
            memWrite <= 1'b0;
            memAddr <= 8'h00;
            memWdata <= 32'h0000_0000;
        end else begin
            case (state)
                ST_IDLE: begin
                    waitCnt <= 22'd0;
                    if (wrStart) begin
                        writeDone <= 1'b0;
                        if (!wrLegal) begin
                            writeDone <= 1'b1; // R04
                        end else if (isShadow(wrAddr)) begin
                            shadowMem[wrAddr[4:0]] <= wrData; // R22 R24
                            writeDone <= 1'b1;
                        end else begin
                            writeBusy <= 1'b1;
                            memReq <= 1'b1;
                            memWrite <= 1'b1;
                            memAddr <= wrAddr;
                            memWdata <= wrData;
                            state <= ST_WAIT;
                        end
                    end else if (rdStart) begin // R14
                        readDone <= 1'b0;
                        if (isShadow(rdAddr)) begin
                            rdData <= shadowMem[rdAddr[4:0]] & 32'hFCFF_FFFF; // R16 R22
                            readDone <= 1'b1;
                        end else if (rdAddr > `XMA_EE_END) begin
                            rdData <= 32'h0000_0000;
                            readDone <= 1'b1;
                        end else begin
                            readBusy <= 1'b1;
                            memReq <= 1'b1;
                            memWrite <= 1'b0;
                            memAddr <= rdAddr;
                            state <= ST_WAIT;
                        end
                    end
                end
                ST_WAIT: begin
                    memReq <= 1'b0;
                    waitCnt <= waitCnt + 22'd1;
                    if (writeBusy && (memDone || memAbort || wrTimeout)) begin // R24
                        writeBusy <= 1'b0;
                        writeDone <= 1'b1;
                        memWrite <= 1'b0;
                        state <= ST_IDLE;
                    end else if (readBusy && (memDone || rdTimeout)) begin // R15
                        rdData <= memDone ? {memRdata[31:26], 2'b00, memRdata[23:0]} : 32'h0000_0000; // R19
                        readBusy <= 1'b0;
                        readDone <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read-back path
    // ---------------------------------------------------------------
    // read data is not frozen during an access; the host must wait for done
    always @(posedge core_clk) begin
        if (srst) begin
            busRdata <= `XMA_RESET_BYTE;
        end else begin
            case (addrS2)
                `XMA_ADR_EWA_LO: busRdata <= wrAddr;
                `XMA_ADR_EWD0: busRdata <= wrData[31:24];
                `XMA_ADR_EWD1: busRdata <= wrData[23:16];
                `XMA_ADR_EWD2: busRdata <= wrData[15:8];
                `XMA_ADR_EWD3: busRdata <= wrData[7:0];
                `XMA_ADR_WCTL_HI: busRdata <= {7'h00, writeBusy};
                `XMA_ADR_WCTL_LO: busRdata <= {7'h00, writeDone}; // R03
                `XMA_ADR_ERA_LO: busRdata <= rdAddr;
                `XMA_ADR_RCTL_HI: busRdata <= {7'h00, readBusy};
                `XMA_ADR_RCTL_LO: busRdata <= {7'h00, readDone}; // R17
                `XMA_ADR_ERD0: busRdata <= rdData[31:24]; // R20
                `XMA_ADR_ERD1: busRdata <= rdData[23:16];
                `XMA_ADR_ERD2: busRdata <= rdData[15:8];
                `XMA_ADR_ERD3: busRdata <= rdData[7:0];
                `XMA_ADR_CTRL_HI: busRdata <= {special, 4'h0}; // R09
                default: busRdata <= `XMA_RESET_BYTE;
            endcase
        end
    end
endmodule
